// >>> verification/core_model.sv
// processor core stand-in that answers the two request lines
`timescale 1ns/1ns
module core_model
(
    input wire logic mclk_in,
    input wire logic fast_request_n_in,
    input wire logic normal_request_n_in,
    output logic ack_out,
    output logic eoi_out
);
    // ------------------------------------------------------------
    // service handshake
    // ------------------------------------------------------------
    // both strobes idle until the bench asks for service
    initial
    begin
        ack_out = 1'b0;
        eoi_out = 1'b0;
    end

    // a line held low is a request; the delay lets service be slow
    task automatic take(input int delay);
        int n;
        n = 0;
        while (fast_request_n_in && normal_request_n_in && n < 20)
        begin
            @(posedge mclk_in);
            n++;
        end
        repeat (delay + 1) @(posedge mclk_in);
        ack_out <= 1'b1;
        @(posedge mclk_in);
        ack_out <= 1'b0;
    endtask

    // one end-of-service pulse retires the top level in service
    task automatic retire();
        @(posedge mclk_in);
        eoi_out <= 1'b1;
        @(posedge mclk_in);
        eoi_out <= 1'b0;
    endtask
endmodule

// >>> verification/priority_interrupt_unit_test.sv
// self-checking bench for the priority interrupt unit
`timescale 1ns/1ns
module priority_interrupt_unit_test;
    import pic_pkg::*;

    // ------------------------------------------------------------
    // design signals and reference state
    // ------------------------------------------------------------
    logic mclk_in;
    logic reset_n_in;
    logic [63:0] src_in;
    logic wdt_req_in;
    chan_cfg_s chan_cfg_in [64];
    logic [63:0] enable_in;
    logic ack_in;
    logic eoi_in;
    logic fast_request_n_out;
    logic normal_request_n_out;
    logic [63:0] pending_out;
    logic [5:0] active_chan_out;
    logic [7:0] in_service_out;
    logic [63:0] src_v;
    logic [63:0] en_v;
    logic [63:0] pend_m;
    logic [2:0] pr [64];
    sense_e sn [64];
    logic wdt;
    logic [7:0] isv;
    logic [5:0] act;
    bit w_fast;
    bit w_norm;
    int w_chan;
    int errors;
    int checked;

    priority_interrupt_unit priority_interrupt_unit_inst
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .src_in(src_in),
        .wdt_req_in(wdt_req_in),
        .chan_cfg_in(chan_cfg_in),
        .enable_in(enable_in),
        .ack_in(ack_in),
        .eoi_in(eoi_in),
        .fast_request_n_out(fast_request_n_out),
        .normal_request_n_out(normal_request_n_out),
        .pending_out(pending_out),
        .active_chan_out(active_chan_out),
        .in_service_out(in_service_out)
    );

    core_model core_model_inst
    (
        .mclk_in(mclk_in),
        .fast_request_n_in(fast_request_n_out),
        .normal_request_n_in(normal_request_n_out),
        .ack_out(ack_in),
        .eoi_out(eoi_in)
    );

    // ------------------------------------------------------------
    // comparison and verdict
    // ------------------------------------------------------------
    task automatic check_vec(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp,
        input logic got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    // pending of level-sensed channels; the watchdog owns channel 1
    function automatic logic [63:0] level_pend();
        logic [63:0] p;
        logic raw;
        p = '0;
        for (int c = 0; c < CHAN_DEFINED; c++)
        begin
            raw = (c == int'(WDT_CHAN)) ? wdt : src_v[c];
            p[c] = (sn[c] == SENSE_HIGH) ? raw : !raw;
        end
        return p;
    endfunction

    // fast beats normal; lower level, then lower channel, wins
    task automatic arbitrate(input logic [63:0] p);
        int top;
        int best;
        int nchan;
        top = 8;
        best = 8;
        nchan = -1;
        w_fast = 1'b0;
        w_chan = -1;
        for (int l = 7; l >= 0; l--)
            if (isv[l]) top = l;
        for (int c = 0; c < CHAN_DEFINED; c++)
        begin
            if (p[c] && en_v[c] && pr[c] == 0 && !isv[0] && !w_fast)
            begin
                w_fast = 1'b1;
                w_chan = c;
            end
            if (p[c] && en_v[c] && pr[c] != 0 && pr[c] < top && pr[c] < best)
            begin
                best = pr[c];
                nchan = c;
            end
        end
        w_norm = (nchan >= 0);
        if (!w_fast) w_chan = nchan;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic check_all();
        arbitrate(pend_m);
        check_vec("pending", pend_m, pending_out);
        check_bit("fast_request_n", !w_fast, fast_request_n_out);
        check_bit("normal_request_n", !w_norm, normal_request_n_out);
        check_vec("in_service", 64'(isv), 64'(in_service_out));
        check_vec("active_chan", 64'(act), 64'(active_chan_out));
    endtask

    // every channel's source, level, sense and enable are driven on the same clock edge
    task automatic drive();
        @(posedge mclk_in);
        src_in <= src_v;
        wdt_req_in <= wdt;
        enable_in <= en_v;
        for (int c = 0; c < 64; c++)
            chan_cfg_in[c] <= '{prio: pr[c], sense: sn[c]};
    endtask

    task automatic serve(input int d);
        arbitrate(pend_m);
        core_model_inst.take(d);
        isv[pr[w_chan]] = 1'b1;
        act = 6'(w_chan);
        if (sn[w_chan] == SENSE_FALL || sn[w_chan] == SENSE_RISE)
            pend_m[w_chan] = 1'b0;
        settle(3);
        check_all();
    endtask

    task automatic retire_top();
        bit done;
        done = 1'b0;
        core_model_inst.retire();
        for (int l = 0; l < LEVEL_NUM; l++)
            if (isv[l] && !done)
            begin
                isv[l] = 1'b0;
                done = 1'b1;
            end
        settle(3);
        check_all();
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk_in = 1'b0;
        forever #10 mclk_in = !mclk_in;
    end

    // the run needs a few hundred cycles; this bounds a hang
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        errors++;
        finish_test();
    end

    initial
    begin
        errors = 0;
        checked = 0;
        reset_n_in = 1'b0;
        src_in = '0;
        wdt_req_in = 1'b0;
        enable_in = '0;
        for (int c = 0; c < 64; c++)
            chan_cfg_in[c] = '{prio: 3'h7, sense: SENSE_HIGH};
        isv = '0;
        act = '0;
        pend_m = '0;
        void'($urandom(74253));
        settle(3);
        check_vec("pending", 64'h0, pending_out);
        check_bit("fast_request_n", 1'b1, fast_request_n_out);
        check_bit("normal_request_n", 1'b1, normal_request_n_out);
        @(posedge mclk_in);
        @(posedge mclk_in);
        reset_n_in <= 1'b1;
        // random level-sensed traffic, at most one channel served and retired per pass
        for (int it = 0; it < 20; it++)
        begin
            for (int c = 0; c < 64; c++)
            begin
                pr[c] = 3'($urandom_range(0, 7));
                sn[c] = $urandom_range(0, 1) ? SENSE_HIGH : SENSE_LOW;
            end
            src_v = {$urandom, $urandom};
            en_v = {$urandom, $urandom} & {$urandom, $urandom};
            wdt = 1'($urandom_range(0, 1));
            drive();
            settle(5);
            pend_m = level_pend();
            check_all();
            for (int k = 0; k < 8; k++)
            begin
                arbitrate(pend_m);
                if (w_chan >= 0) serve($urandom_range(0, 3));
            end
            while (isv != 0) retire_top();
        end
        // edge channels: rise on 5 at level 2, fall on 7 at level 0
        for (int c = 0; c < 64; c++)
            sn[c] = SENSE_HIGH;
        src_v = 64'h80;
        wdt = 1'b0;
        en_v = 64'hA0;
        pr[5] = 3'h2;
        sn[5] = SENSE_RISE;
        pr[7] = 3'h0;
        sn[7] = SENSE_FALL;
        drive();
        settle(6);
        pend_m = '0;
        check_all();
        src_v = 64'hA0;
        drive();
        settle(5);
        pend_m = 64'h20;
        check_all();
        serve(1);
        src_v = 64'h20;
        drive();
        settle(5);
        pend_m = 64'h80;
        check_all();
        serve(0);
        retire_top();
        retire_top();
        finish_test();
    end
endmodule

// >>> verilog/pic_pkg.sv
// constants, configuration types and carriers for the priority interrupt unit
package pic_pkg;

    // ------------------------------------------------------------
    // channel map
    // ------------------------------------------------------------
    localparam int CHAN_NUM = 64;
    localparam int CHAN_DEFINED = 61;
    localparam int LEVEL_NUM = 8;
    localparam logic [5:0] WDT_CHAN = 6'h01;
    localparam logic [2:0] FAST_LEVEL = 3'h0;
    localparam logic [3:0] NO_LEVEL = 4'h8;
    localparam logic [63:0] DEFINED_MASK = 64'h1FFF_FFFF_FFFF_FFFF;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SVC_RESET = 8'h00;
    localparam logic [63:0] PEND_RESET = 64'h0;
    localparam logic [5:0] CHAN_RESET = 6'h00;

    // detection mode of one channel
    typedef enum logic [1:0]
    {
        SENSE_LOW = 2'h0,
        SENSE_HIGH = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_e;

    // per-channel configuration written by software
    typedef struct packed
    {
        logic [2:0] prio;
        sense_e sense;
    } chan_cfg_s;

    // result of a lowest-channel search
    typedef struct packed
    {
        logic found;
        logic [5:0] chan;
    } pick_s;

endpackage

// >>> verilog/priority_interrupt_unit.sv
// eight-level priority interrupt unit with fast and normal request lines
`timescale 1ns/1ns
// How it works
// - Up to 64 request channels are accepted, each source on its own channel.
// - Only the low 61 channels are defined and channel 1 carries the watchdog.
// - Each channel has a level 0..7, where 0 ranks highest.
// - Within one level the lower channel number wins.
// - The lowest enabled pending level 0 channel drives the fast request.
// - Levels 1..7 only ever drive the normal request.
// - A fast request may assert while a normal one is in service.
// - While a level is in service, equal and lower levels are held off.
// - Each channel senses low level, high level, falling or rising edge.
// - Internal sources are active high and the sense mode applies on top.
// - A readable pending flag exists for every channel.
// - A disabled channel neither arbitrates nor drives a request line.
// - Edge flags clear themselves when the channel enters service.
// - Both request lines are driven low to request.
// - Configuration, mask and status are reached by software.
module priority_interrupt_unit
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [63:0] src_in,
    input wire logic wdt_req_in,
    input wire pic_pkg::chan_cfg_s chan_cfg_in [64],
    input wire logic [63:0] enable_in,
    input wire logic ack_in,
    input wire logic eoi_in,
    output logic fast_request_n_out,
    output logic normal_request_n_out,
    output logic [63:0] pending_out,
    output logic [5:0] active_chan_out,
    output logic [7:0] in_service_out
);
    import pic_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest set bit of a channel vector
    function automatic pick_s first_set(input logic [63:0] v);
        pick_s p;
        p = '0;
        for (int i = CHAN_NUM - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                p.found = 1'b1;
                p.chan = 6'(i);
            end
        end
        return p;
    endfunction

    // lowest set bit of the level-in-service bitmap, NO_LEVEL if none
    function automatic logic [3:0] first_level(input logic [7:0] v);
        logic [3:0] l;
        l = NO_LEVEL;
        for (int i = LEVEL_NUM - 1; i >= 0; i--)
        begin
            if (v[i])
                l = 4'(i);
        end
        return l;
    endfunction

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    logic [63:0] src_map;
    logic [63:0] pend;
    logic [63:0] pend_def;
    logic [63:0] clr_vec;
    logic [63:0] elig;
    logic [63:0] lvl_vec [8];
    logic [7:0] svc_r;
    logic [7:0] svc_nxt;
    logic [3:0] cur_lvl;
    logic [3:0] norm_lvl;
    pick_s fast_pick;
    pick_s norm_pick;
    pick_s lvl_pick [8];
    logic fast_any;
    logic norm_any;
    logic [5:0] win_chan;
    logic [2:0] win_lvl;

    // watchdog request takes channel 1 in place of the generic input
    always_comb
    begin
        src_map = src_in & DEFINED_MASK;
        src_map[WDT_CHAN] = wdt_req_in;
    end

    genvar g;
    generate
        for (g = 0; g < CHAN_NUM; g++)
        begin : g_chan
            req_detect u_det
            (
                .mclk_in(mclk_in),
                .reset_n_in(reset_n_in),
                .src_in(src_map[g]),
                .sense_in(chan_cfg_in[g].sense),
                .clr_in(clr_vec[g]),
                .pend_out(pend[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    // undefined channels never pend, whatever their sense mode says
    assign pend_def = pend & DEFINED_MASK;
    // software enables gate arbitration; levels come from its config
    assign elig = pend_def & enable_in;

    always_comb
    begin
        for (int l = 0; l < LEVEL_NUM; l++)
        begin
            for (int c = 0; c < CHAN_NUM; c++)
                lvl_vec[l][c] = elig[c] && (chan_cfg_in[c].prio == 3'(l));
            lvl_pick[l] = first_set(lvl_vec[l]);
        end
    end

    assign cur_lvl = first_level(svc_r);
    assign fast_pick = lvl_pick[0];
    // level 0 nests over any normal service, but not over itself
    assign fast_any = fast_pick.found && !svc_r[0];

    // lowest non-zero level that ranks above the one in service
    always_comb
    begin
        norm_lvl = NO_LEVEL;
        norm_pick = '0;
        for (int l = LEVEL_NUM - 1; l >= 1; l--)
        begin
            if (lvl_pick[l].found && 4'(l) < cur_lvl)
            begin
                norm_lvl = 4'(l);
                norm_pick = lvl_pick[l];
            end
        end
    end
    assign norm_any = norm_pick.found;

    // fast source is the one taken on acknowledge when both are up
    assign win_chan = fast_any ? fast_pick.chan : norm_pick.chan;
    assign win_lvl = fast_any ? FAST_LEVEL : norm_lvl[2:0];
    wire take = ack_in && (fast_any || norm_any);
    assign clr_vec = take ? (64'h1 << win_chan) : 64'h0;

    // end of service retires the highest level, acknowledge pushes one
    always_comb
    begin
        svc_nxt = svc_r;
        if (eoi_in && cur_lvl != NO_LEVEL)
            svc_nxt[cur_lvl[2:0]] = 1'b0;
        if (take)
            svc_nxt[win_lvl] = 1'b1;
    end

    // ------------------------------------------------------------
    // state and outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            svc_r <= SVC_RESET;
            fast_request_n_out <= 1'b1;
            normal_request_n_out <= 1'b1;
            pending_out <= PEND_RESET;
            active_chan_out <= CHAN_RESET;
        end
        else
        begin
            svc_r <= svc_nxt;
            fast_request_n_out <= ~fast_any;
            normal_request_n_out <= ~norm_any;
            pending_out <= pend_def;
            if (take)
                active_chan_out <= win_chan;
        end
    end

    assign in_service_out = svc_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    property p_fast_assert;
        fast_any |=> !fast_request_n_out;
    endproperty
    a_fast_assert: assert property (p_fast_assert)
        else $error("fast request not driven low");

    property p_low_idle;
        !fast_any && !norm_any |=> fast_request_n_out && normal_request_n_out;
    endproperty
    a_low_idle: assert property (p_low_idle)
        else $error("request line low with nothing pending");

    // some eligible channel outside level 0 must stand behind the line
    wire norm_cand = |(elig & ~lvl_vec[0]);

    property p_normal_level;
        !normal_request_n_out |-> $past(norm_cand);
    endproperty
    a_normal_level: assert property (p_normal_level)
        else $error("level 0 routed to normal request");

    property p_mask_lower;
        svc_r[0] || svc_r[1] |=> normal_request_n_out;
    endproperty
    a_mask_lower: assert property (p_mask_lower)
        else $error("lower level nested over service");

    property p_fast_nests;
        svc_r != 8'h00 && !svc_r[0] && fast_pick.found |=> !fast_request_n_out;
    endproperty
    a_fast_nests: assert property (p_fast_nests)
        else $error("fast request blocked by normal service");

    property p_enabled_only;
        fast_any |-> enable_in[fast_pick.chan] && pend[fast_pick.chan];
    endproperty
    a_enabled_only: assert property (p_enabled_only)
        else $error("disabled channel selected");

    property p_lowest_chan;
        fast_any |-> (lvl_vec[0] & ((64'h1 << fast_pick.chan) - 64'h1)) == 64'h0;
    endproperty
    a_lowest_chan: assert property (p_lowest_chan)
        else $error("higher channel chosen over lower one");

    property p_status;
        ##1 pending_out == $past(pend_def);
    endproperty
    a_status: assert property (p_status)
        else $error("pending status lags or is wrong");

    property p_service_push;
        take && !eoi_in |=> svc_r[$past(win_lvl)];
    endproperty
    a_service_push: assert property (p_service_push)
        else $error("acknowledged level not marked in service");
endmodule

// >>> verilog/req_detect.sv
// one channel: input synchroniser, sensitivity selection, edge flag
`timescale 1ns/1ns
module req_detect
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic src_in,
    input wire pic_pkg::sense_e sense_in,
    input wire logic clr_in,
    output logic pend_out
);
    import pic_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic edge_r;
    logic edge_nxt;
    wire is_edge = sense_in[1];
    wire rise = sync2_r & ~prev_r;
    wire fall = ~sync2_r & prev_r;
    wire edge_now = (sense_in == SENSE_RISE) ? rise : fall;

    // ------------------------------------------------------------
    // synchroniser; sources may be pins, so two flops come first
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= src_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // edge flag: a new edge in the clear cycle wins over the clear
    assign edge_nxt = (edge_r & ~clr_in) | (is_edge & edge_now);

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            edge_r <= 1'b0;
        else
            edge_r <= edge_nxt;
    end

    // level modes follow the synchronised level directly
    assign pend_out = is_edge ? edge_r
                    : (sense_in == SENSE_HIGH) ? sync2_r : ~sync2_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_clear_quiet;
        is_edge && clr_in && !edge_now;
    endsequence

    property p_edge_autoclear;
        s_clear_quiet ##0 $stable(sense_in) |=> !pend_out;
    endproperty
    a_edge_autoclear: assert property (p_edge_autoclear)
        else $error("edge flag not cleared on service");

    property p_rise_sets;
        (sense_in == SENSE_RISE) && rise && $stable(sense_in) |=> pend_out;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge not latched");

    property p_high_level;
        (sense_in == SENSE_HIGH) |-> pend_out == $past(sync1_r);
    endproperty
    a_high_level: assert property (p_high_level)
        else $error("high level mode does not follow source");
endmodule
